// file: logic/ucr_params.svh
// Register indices, field positions, masks and reset values of the channel register map
`ifndef UCR_PARAMS_SVH
`define UCR_PARAMS_SVH
// Register indices; byte address is four times the index
`define UCR_IDX_DATA 5'h00
`define UCR_IDX_IER 5'h01
`define UCR_IDX_FCR 5'h02
`define UCR_IDX_LCR 5'h03
`define UCR_IDX_MCR 5'h04
`define UCR_IDX_LSR 5'h05
`define UCR_IDX_MSR 5'h06
`define UCR_IDX_SPR 5'h07
`define UCR_IDX_FEATURE_CONTROL 5'h08
`define UCR_IDX_EFR 5'h09
`define UCR_IDX_EVSTAT 5'h10
`define UCR_IDX_EVMASK 5'h11
// Field positions
`define UCR_LCR_DLAB 7
`define UCR_EFR_ENH 4
`define UCR_MCR_LOOP 4
`define UCR_FCR_EN 0
`define UCR_IER_RXD 0
`define UCR_IER_TXE 1
`define UCR_IER_LINE 2
`define UCR_IER_MODEM 3
// Masks of gated, reserved and self-clearing bits
`define UCR_IER_ENH 8'hE0
`define UCR_IER_RSVD 8'h10
`define UCR_ISR_ENH 8'h30
`define UCR_FCR_ENH 8'h30
`define UCR_FCR_SELF 8'h06
`define UCR_MCR_ENH 8'hE0
// Interrupt source codes
`define UCR_SRC_LINE 4'h6
`define UCR_SRC_RXD 4'h4
`define UCR_SRC_TXE 4'h2
`define UCR_SRC_MODEM 4'h0
`define UCR_SRC_NONE 4'h1
// Event status bits
`define UCR_EV_RX 0
`define UCR_EV_TX 1
`define UCR_EV_LINE 2
`define UCR_EV_MODEM 3
`define UCR_EV_SPEC 4
// Reset values
`define UCR_RST_BYTE 8'h00
`endif

// file: logic/ucr_pkg.sv
// Types of the channel register block
package ucr_pkg;
   typedef struct packed {
      logic wait_req;
      logic [31:0] rdata;
      logic [7:0] dll;
      logic [7:0] divisor_high;
      logic [7:0] divisor_fraction;
      logic [7:0] interrupt_enable;
      logic [7:0] fifo_control;
      logic [7:0] line_control;
      logic [7:0] modem_control;
      logic [7:0] dly;
      logic [7:0] scratch_pad;
      logic [7:0] feature_control;
      logic [7:0] enhanced_function;
      logic [7:0] tx_holding;
      logic [7:0] rx_holding;
      logic tx_load;
      logic dr;
      logic oe;
      logic pe;
      logic fe;
      logic bi;
      logic thre;
      logic xoff_flag;
      logic flow_flag;
      logic [3:0] delta;
      logic [3:0] mprev;
      logic [4:0] ev;
      logic [4:0] evmask;
      logic irq;
   } ucr_state_type;
endpackage : ucr_pkg

// file: logic/ucr_regs.sv
// One UART channel register map behind an Avalon-MM slave
// How it works
// - With the divisor-latch bit set, indices 0, 1 and 2 reach divisor low, high and fraction.
// - With the divisor-latch bit clear, index 0 reads the received byte and writes the send byte.
// - The fraction register holds fraction, fast infrared, parity check, multidrop and polarity.
// - Interrupt enable holds four classic enables, a zero bit 4 and three enhanced enables.
// - Interrupt status gives source code, special flag, flow flag and FIFO-enabled bits.
// - With the divisor-latch bit clear, a write at index 2 reaches FIFO control with enable, two resets, DMA and two triggers.
// - Line control holds word length, stop bits, parity fields, break and divisor latch.
// - Modem control holds DTR, RTS, flow select, send now, loopback, resume, infrared, prescaler.
// - Line status reports ready, overrun, parity, framing, break, both empties and error summary.
// - Reading index 6 gives four modem change flags and four modem levels.
// - Writing index 6 loads turnaround delay and four disable bits.
// - Index 7 is a plain scratch byte with no effect on the channel.
// - Feature control holds hysteresis, infrared inversion, auto direction and trigger table.
// - Enhanced bits are writable and visible only while the enhanced enable is set.
`timescale 1ns/1ps
`include "ucr_params.svh"
module ucr_regs #(
   parameter int ADDR_W = 7
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_valid_i,
   input wire logic rx_parity_err_i,
   input wire logic rx_framing_err_i,
   input wire logic rx_break_i,
   input wire logic tx_taken_i,
   input wire logic tx_shift_empty_i,
   input wire logic special_char_i,
   input wire logic flow_change_i,
   input wire logic cts_i,
   input wire logic dsr_i,
   input wire logic ri_i,
   input wire logic cd_i,
   output logic [7:0] tx_byte_o,
   output logic tx_load_o,
   output logic [15:0] divisor_o,
   output logic [7:0] divisor_fraction_o,
   output logic [7:0] line_control_o,
   output logic [7:0] modem_control_o,
   output logic [7:0] fifo_control_o,
   output logic [7:0] turnaround_delay_o,
   output logic [7:0] feature_control_o,
   output logic [7:0] enhanced_function_o,
   output logic irq_o
);
   ucr_pkg::ucr_state_type state_q;
   ucr_pkg::ucr_state_type state_d;
   logic req;
   logic acc;
   logic [4:0] idx;
   logic [7:0] wd;
   logic dlab;
   logic enh;

   // Keep gated bits when enhanced writes are off
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] m, input logic en);
      merge = en ? nw : ((nw & ~m) | (old & m));
   endfunction : merge

   // Hide gated bits when enhanced reads are off
   function automatic logic [7:0] gate(input logic [7:0] v, input logic [7:0] m,
                                       input logic en);
      gate = en ? v : (v & ~m);
   endfunction : gate

   // Request decode; a request is accepted when waitrequest is low
   assign req = avs_read_i | avs_write_i;
   assign acc = req & ~state_q.wait_req;
   assign idx = avs_address_i[ADDR_W-1:2];
   assign wd = avs_writedata_i[7:0];
   assign dlab = state_q.line_control[`UCR_LCR_DLAB];
   assign enh = state_q.enhanced_function[`UCR_EFR_ENH];

   // Next-state logic for the whole register file
   always_comb begin
      logic [3:0] lvl;
      logic [3:0] chg;
      logic [3:0] src;
      logic [7:0] rv;
      lvl = '0;
      chg = '0;
      src = `UCR_SRC_NONE;
      rv = `UCR_RST_BYTE;
      state_d = state_q;
      state_d.tx_load = 1'b0;
      // reset bits act for one cycle
      state_d.fifo_control = state_q.fifo_control & ~`UCR_FCR_SELF;
      state_d.wait_req = ~(req & state_q.wait_req);
      // loopback feeds modem levels from modem control
      if (state_q.modem_control[`UCR_MCR_LOOP]) begin
         lvl = {state_q.modem_control[3], state_q.modem_control[2], state_q.modem_control[0], state_q.modem_control[1]};
      end else begin
         lvl = {cd_i, ri_i, dsr_i, cts_i};
      end
      if (state_q.interrupt_enable[`UCR_IER_LINE] & (state_q.oe | state_q.pe | state_q.fe | state_q.bi)) begin
         src = `UCR_SRC_LINE;
      end else if (state_q.interrupt_enable[`UCR_IER_RXD] & state_q.dr) begin
         src = `UCR_SRC_RXD;
      end else if (state_q.interrupt_enable[`UCR_IER_TXE] & state_q.thre) begin
         src = `UCR_SRC_TXE;
      end else if (state_q.interrupt_enable[`UCR_IER_MODEM] & (|state_q.delta)) begin
         src = `UCR_SRC_MODEM;
      end
      // Read data mux, latched in the first cycle of a request
      case (idx)
         `UCR_IDX_DATA: rv = dlab ? state_q.dll : state_q.rx_holding;
         `UCR_IDX_IER: rv = dlab ? state_q.divisor_high :
                          gate(state_q.interrupt_enable & ~`UCR_IER_RSVD, `UCR_IER_ENH, enh);
         `UCR_IDX_FCR: rv = dlab ? state_q.divisor_fraction :
                          gate({{2{state_q.fifo_control[`UCR_FCR_EN]}}, state_q.flow_flag,
                                state_q.xoff_flag, src}, `UCR_ISR_ENH, enh);
         `UCR_IDX_LCR: rv = state_q.line_control;
         `UCR_IDX_MCR: rv = gate(state_q.modem_control, `UCR_MCR_ENH, enh);
         `UCR_IDX_LSR: rv = {state_q.pe | state_q.fe | state_q.bi, tx_shift_empty_i,
                             state_q.thre, state_q.bi, state_q.fe, state_q.pe,
                             state_q.oe, state_q.dr};
         `UCR_IDX_MSR: rv = {state_q.mprev, state_q.delta};
         `UCR_IDX_SPR: rv = state_q.scratch_pad;
         `UCR_IDX_FEATURE_CONTROL: rv = state_q.feature_control;
         `UCR_IDX_EFR: rv = state_q.enhanced_function;
         `UCR_IDX_EVSTAT: rv = {3'h0, state_q.ev};
         `UCR_IDX_EVMASK: rv = {3'h0, state_q.evmask};
         default: rv = `UCR_RST_BYTE;
      endcase
      if (avs_read_i & state_q.wait_req) begin
         state_d.rdata = {24'h000000, rv};
      end
      // read side effects touch only the read view
      if (acc & avs_read_i) begin
         case (idx)
            `UCR_IDX_DATA: if (!dlab) state_d.dr = 1'b0;
            `UCR_IDX_FCR: if (!dlab) begin
               state_d.xoff_flag = 1'b0;
               state_d.flow_flag = 1'b0;
            end
            `UCR_IDX_LSR: begin
               state_d.oe = 1'b0;
               state_d.pe = 1'b0;
               state_d.fe = 1'b0;
               state_d.bi = 1'b0;
            end
            `UCR_IDX_MSR: state_d.delta = 4'h0;
            default: ;
         endcase
      end
      // writes reach only the write view
      if (acc & avs_write_i & avs_byteenable_i[0]) begin
         case (idx)
            `UCR_IDX_DATA: begin
               if (dlab) begin
                  state_d.dll = wd;
               end else begin
                  state_d.tx_holding = wd;
                  state_d.tx_load = 1'b1;
                  state_d.thre = 1'b0;
               end
            end
            `UCR_IDX_IER: begin
               if (dlab) state_d.divisor_high = wd;
               else state_d.interrupt_enable = merge(state_q.interrupt_enable, wd & ~`UCR_IER_RSVD, `UCR_IER_ENH, enh);
            end
            `UCR_IDX_FCR: begin
               if (dlab) state_d.divisor_fraction = wd;
               else state_d.fifo_control = merge(state_q.fifo_control, wd, `UCR_FCR_ENH, enh);
            end
            `UCR_IDX_LCR: state_d.line_control = wd;
            `UCR_IDX_MCR: state_d.modem_control = merge(state_q.modem_control, wd, `UCR_MCR_ENH, enh);
            `UCR_IDX_MSR: if (enh) state_d.dly = wd;
            `UCR_IDX_SPR: state_d.scratch_pad = wd;
            `UCR_IDX_FEATURE_CONTROL: state_d.feature_control = wd;
            `UCR_IDX_EFR: state_d.enhanced_function = wd;
            `UCR_IDX_EVSTAT: state_d.ev = state_q.ev & ~wd[4:0];
            `UCR_IDX_EVMASK: state_d.evmask = wd[4:0];
            default: ;
         endcase
      end
      // Hardware events last, so a set wins over a clear
      if (rx_valid_i) begin
         state_d.rx_holding = rx_byte_i;
         state_d.dr = 1'b1;
         state_d.ev[`UCR_EV_RX] = 1'b1;
         if (state_q.dr) state_d.oe = 1'b1;
         if (rx_parity_err_i) state_d.pe = 1'b1;
         if (rx_framing_err_i) state_d.fe = 1'b1;
         if (rx_break_i) state_d.bi = 1'b1;
         if (state_q.dr | rx_parity_err_i | rx_framing_err_i | rx_break_i) begin
            state_d.ev[`UCR_EV_LINE] = 1'b1;
         end
      end
      if (tx_taken_i) begin
         state_d.thre = 1'b1;
         state_d.ev[`UCR_EV_TX] = 1'b1;
      end
      // change flags; ring flag on trailing edge
      chg = (state_q.mprev ^ lvl) & {1'b1, state_q.mprev[2], 2'b11};
      state_d.mprev = lvl;
      state_d.delta = state_d.delta | chg;
      if (|chg) state_d.ev[`UCR_EV_MODEM] = 1'b1;
      if (special_char_i & enh) begin
         state_d.xoff_flag = 1'b1;
         state_d.ev[`UCR_EV_SPEC] = 1'b1;
      end
      if (flow_change_i & enh) state_d.flow_flag = 1'b1;
      state_d.irq = |(state_d.ev & state_d.evmask);
      if (!rst_n_i) begin
         state_d = '0;
         state_d.wait_req = 1'b1;
         state_d.thre = 1'b1;
         state_d.mprev = lvl;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      state_q <= state_d;
   end

   // Outputs straight from the state register
   assign avs_readdata_o = state_q.rdata;
   assign avs_waitrequest_o = state_q.wait_req;
   assign tx_byte_o = state_q.tx_holding;
   assign tx_load_o = state_q.tx_load;
   assign divisor_o = {state_q.divisor_high, state_q.dll};
   assign divisor_fraction_o = state_q.divisor_fraction;
   assign line_control_o = state_q.line_control;
   assign modem_control_o = state_q.modem_control;
   assign fifo_control_o = state_q.fifo_control;
   assign turnaround_delay_o = state_q.dly;
   assign feature_control_o = state_q.feature_control;
   assign enhanced_function_o = state_q.enhanced_function;
   assign irq_o = state_q.irq;

   // send byte write raises load pulse
   a_tx_load_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_DATA && !dlab
      |=> tx_load_o && tx_byte_o == $past(avs_writedata_i[7:0]) ##1 !tx_load_o)
      else $error("send byte write did not load once");
   a_divisor_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_DATA && dlab
      |=> divisor_o[7:0] == $past(avs_writedata_i[7:0]) && !tx_load_o)
      else $error("divisor low not written");
   a_ier_bit_four: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_read_i && idx == `UCR_IDX_IER && !dlab |-> avs_readdata_o[4] == 1'b0)
      else $error("interrupt enable bit 4 not zero");
   a_enh_hidden: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_read_i && idx == `UCR_IDX_IER && !dlab && !$past(enh)
      |-> avs_readdata_o[7:5] == 3'h0)
      else $error("enhanced enables visible");
   a_lcr_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_LCR
      |=> line_control_o == $past(avs_writedata_i[7:0]))
      else $error("line control not written");
   // second byte without read sets overrun
   a_overrun_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      rx_valid_i && state_q.dr |=> state_q.oe && state_q.dr)
      else $error("overrun not flagged");
   // receive FIFO reset bit lasts one cycle
   a_fifo_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_FCR && !dlab
      && avs_writedata_i[1] |=> fifo_control_o[1] ##1 !fifo_control_o[1])
      else $error("receive FIFO reset not a pulse");
   a_reset_vals: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> line_control_o == 8'h00 && fifo_control_o == 8'h00
      && modem_control_o == 8'h00 && avs_waitrequest_o)
      else $error("reset defaults wrong");
   // Bus answer one cycle after request
   a_one_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("waitrequest timing wrong");

   // Further register checks, one property per field group except two for modem control and delay
   // divisor high write
   a_divisor_high: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_IER && dlab
      |=> divisor_o[15:8] == $past(avs_writedata_i[7:0]))
      else $error("divisor high not written");
   a_fraction_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_FCR && dlab
      |=> divisor_fraction_o == $past(avs_writedata_i[7:0]))
      else $error("fraction not written");
   // interrupt enable write keeps bit 4 clear
   a_ier_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_IER && !dlab && enh
      |=> state_q.interrupt_enable == ($past(avs_writedata_i[7:0]) & ~`UCR_IER_RSVD))
      else $error("interrupt enable not written");
   a_status_fifo_bits: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      avs_read_i && avs_waitrequest_o && idx == `UCR_IDX_FCR && !dlab
      |=> avs_readdata_o[7:6] == {2{$past(fifo_control_o[`UCR_FCR_EN])}})
      else $error("FIFO enabled bits wrong");
   // modem control write with enhanced bits open
   a_mcr_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_MCR && enh
      |=> modem_control_o == $past(avs_writedata_i[7:0]))
      else $error("modem control not written");
   a_mcr_hidden: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      avs_read_i && avs_waitrequest_o && idx == `UCR_IDX_MCR && !enh
      |=> avs_readdata_o[7:5] == 3'h0)
      else $error("enhanced modem bits visible");
   // delay write with enhanced bits open
   a_delay_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_MSR && enh
      |=> turnaround_delay_o == $past(avs_writedata_i[7:0]))
      else $error("delay register not written");
   // delay write refused with enhanced bits closed
   a_delay_gated: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && idx == `UCR_IDX_MSR && !enh
      |=> turnaround_delay_o == $past(turnaround_delay_o))
      else $error("delay register written while gated");
   a_feature_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_FEATURE_CONTROL
      |=> feature_control_o == $past(avs_writedata_i[7:0]))
      else $error("feature control not written");
   a_scratch_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      avs_read_i && avs_waitrequest_o && idx == `UCR_IDX_SPR
      |=> avs_readdata_o[7:0] == $past(state_q.scratch_pad))
      else $error("scratch byte read wrong");
   a_rx_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      avs_read_i && avs_waitrequest_o && idx == `UCR_IDX_DATA && !dlab
      |=> avs_readdata_o[7:0] == $past(state_q.rx_holding))
      else $error("received byte read wrong");
   a_msr_levels: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      avs_read_i && avs_waitrequest_o && idx == `UCR_IDX_MSR
      |=> avs_readdata_o[7:4] == $past(state_q.mprev))
      else $error("modem levels read wrong");
   // line status read clears error bits
   a_lsr_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_read_i && idx == `UCR_IDX_LSR && !rx_valid_i
      |=> !state_q.oe && !state_q.pe && !state_q.fe && !state_q.bi)
      else $error("line errors not cleared");
   // transmit FIFO reset bit lasts one cycle
   a_tx_fifo_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      acc && avs_write_i && avs_byteenable_i[0] && idx == `UCR_IDX_FCR && !dlab
      && avs_writedata_i[2] |=> fifo_control_o[2] ##1 !fifo_control_o[2])
      else $error("transmit FIFO reset not a pulse");
   // quiet outputs after a reset edge
   a_reset_quiet: assert property (@(posedge ref_clk_i)
      !rst_n_i |=> !tx_load_o && !irq_o && divisor_o == {2{`UCR_RST_BYTE}}
      && turnaround_delay_o == `UCR_RST_BYTE)
      else $error("outputs not quiet after reset");
endmodule : ucr_regs

// file: sim/tb_ucr_regs.sv
// Self-checking bench of the channel register map
`timescale 1ns/1ps
module tb_ucr_regs;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] addr;
   logic rd, wr, wreq, txl, irq, to;
   logic [31:0] wdata, rdata;
   logic [7:0] rxb = 8'h00;
   logic rxv = 1'b0;
   logic perr = 1'b0;
   logic shf = 1'b1;
   logic txt = 1'b0;
   logic spc = 1'b0;
   logic flw = 1'b0;
   logic cts = 1'b1;
   logic dsr = 1'b0;
   logic [7:0] txb, frac, line_control, modem_control, fifo_control, dly, feature_control, enhanced_function, q;
   logic [15:0] div;
   int fails = 0;
   int num_checks = 0;

   // Clock at 10 MHz
   always #50 clk = ~clk;

   ucr_regs dut_u (.ref_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .rx_byte_i(rxb), .rx_valid_i(rxv), .rx_parity_err_i(perr),
      .rx_framing_err_i(1'b0), .rx_break_i(1'b0), .tx_taken_i(txt),
      .tx_shift_empty_i(shf), .special_char_i(spc), .flow_change_i(flw),
      .cts_i(cts), .dsr_i(dsr), .ri_i(1'b0), .cd_i(1'b1), .tx_byte_o(txb),
      .tx_load_o(txl), .divisor_o(div), .divisor_fraction_o(frac),
      .line_control_o(line_control), .modem_control_o(modem_control), .fifo_control_o(fifo_control),
      .turnaround_delay_o(dly), .feature_control_o(feature_control),
      .enhanced_function_o(enhanced_function), .irq_o(irq));

   ucr_host host_u (.clk_i(clk), .waitreq_i(wreq), .rdata_i(rdata), .addr_o(addr),
      .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .timeout_o(to));

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic wrr(input logic [4:0] i, input logic [7:0] d);
      host_u.xfer(1'b1, i, d, q);
   endtask : wrr

   task automatic rdr(input logic [4:0] i);
      host_u.xfer(1'b0, i, 8'h00, q);
   endtask : rdr

   // One received byte pulse
   task automatic rx(input logic [7:0] b, input logic pe);
      @(posedge clk);
      rxb <= b;
      perr <= pe;
      rxv <= 1'b1;
      @(posedge clk);
      rxv <= 1'b0;
      perr <= 1'b0;
   endtask : rx

   // One-cycle pulse on the event inputs
   task automatic ev_pulse(input logic t, input logic s, input logic f);
      @(posedge clk);
      txt <= t;
      spc <= s;
      flw <= f;
      @(posedge clk);
      txt <= 1'b0;
      spc <= 1'b0;
      flw <= 1'b0;
   endtask : ev_pulse

   task automatic t_reset;
      rdr(5'h03); chk(q, 8'h00);
      rdr(5'h01); chk(q, 8'h00);
      chk(modem_control, 8'h00);
      chk(irq, 1'b0);
   endtask : t_reset

   task automatic t_divisor;
      wrr(5'h03, 8'h80);
      wrr(5'h00, 8'h34);
      wrr(5'h01, 8'h12);
      wrr(5'h02, 8'h5A);
      @(negedge clk);
      chk(div, 16'h1234);
      chk(frac, 8'h5A);
      rdr(5'h01); chk(q, 8'h12);
      wrr(5'h03, 8'h1B);
      @(negedge clk);
      chk(line_control, 8'h1B);
   endtask : t_divisor

   task automatic t_data;
      wrr(5'h00, 8'hA5);
      @(negedge clk);
      chk(txl, 1'b1);
      chk(txb, 8'hA5);
      rx(8'h3C, 1'b1);
      rdr(5'h05); chk(q & 8'hDF, 8'hC5);
      rdr(5'h00); chk(q, 8'h3C);
      rdr(5'h05); chk(q & 8'hDF, 8'h40);
   endtask : t_data

   task automatic t_enh;
      wrr(5'h06, 8'h55);
      @(negedge clk);
      chk(dly, 8'h00);
      wrr(5'h01, 8'hFF);
      rdr(5'h01); chk(q, 8'h0F);
      wrr(5'h09, 8'h10);
      wrr(5'h01, 8'hFF);
      rdr(5'h01); chk(q, 8'hEF);
      wrr(5'h02, 8'h39);
      @(negedge clk);
      chk(fifo_control, 8'h39);
      rdr(5'h02); chk(q & 8'hC0, 8'hC0);
      wrr(5'h06, 8'hA3);
      @(negedge clk);
      chk(dly, 8'hA3);
      rdr(5'h06); chk(q, 8'h90);
      wrr(5'h04, 8'h02);
      @(negedge clk);
      chk(modem_control, 8'h02);
   endtask : t_enh

   // Send byte taken, special and flow flags, modem changes
   task automatic t_events;
      chk(enhanced_function, 8'h10);
      ev_pulse(1'b1, 1'b1, 1'b1);
      shf <= 1'b0;
      rdr(5'h05); chk(q, 8'h20);
      shf <= 1'b1;
      rdr(5'h02); chk(q, 8'hF2);
      rdr(5'h02); chk(q, 8'hC2);
      cts <= 1'b0;
      dsr <= 1'b1;
      rdr(5'h06); chk(q, 8'hA3);
      rdr(5'h06); chk(q, 8'hA0);
   endtask : t_events

   task automatic t_misc;
      wrr(5'h07, 8'h5A);
      rdr(5'h07); chk(q, 8'h5A);
      wrr(5'h08, 8'hB7);
      @(negedge clk);
      chk(feature_control, 8'hB7);
      rdr(5'h08); chk(q, 8'hB7);
      rdr(5'h0A); chk(q, 8'h00);
   endtask : t_misc

   task automatic t_irq;
      wrr(5'h10, 8'h1F);
      wrr(5'h11, 8'h01);
      rx(8'h11, 1'b0);
      repeat (3) @(negedge clk);
      chk(irq, 1'b1);
      rdr(5'h10); chk(q & 8'h01, 8'h01);
      wrr(5'h10, 8'h01);
      repeat (2) @(negedge clk);
      chk(irq, 1'b0);
      wrr(5'h11, 8'h00);
      rx(8'h22, 1'b0);
      repeat (3) @(negedge clk);
      chk(irq, 1'b0);
   endtask : t_irq

   task automatic report_and_stop;
      if (fails == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // Bus wait that ran out
   always @(posedge to) begin
      fails++;
      report_and_stop;
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_divisor;
      t_data;
      t_enh;
      t_events;
      t_misc;
      t_irq;
      report_and_stop;
   end
endmodule : tb_ucr_regs

// file: sim/ucr_host.sv
// Host model that runs Avalon-MM register cycles
`timescale 1ns/1ps
module ucr_host (
   input wire logic clk_i,
   input wire logic waitreq_i,
   input wire logic [31:0] rdata_i,
   output logic [6:0] addr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [31:0] wdata_o,
   output logic timeout_o
);
   // Idle bus from time zero
   initial begin
      addr_o = 7'h00;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 32'h00000000;
      timeout_o = 1'b0;
   end

   // One cycle, held until waitrequest is sampled low or 20 clocks pass
   task automatic xfer(input logic w, input logic [4:0] idx, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      @(posedge clk_i);
      // index on the upper address bits
      addr_o <= {idx, 2'b00};
      wdata_o <= {24'h000000, d};
      rd_o <= ~w;
      wr_o <= w;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitreq_i !== 1'b0 && n < 20);
      if (n >= 20) timeout_o <= 1'b1;
      q = rdata_i[7:0];
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      wdata_o <= ~{24'h000000, d}; // Stale data does not linger
   endtask : xfer
endmodule : ucr_host
